// ===== sim/maxs_host.sv
/*
  Host processor model that masters the register bank over Avalon-MM.
  Assumes a slave on the same clock that answers with waitrequest low.
*/
`timescale 1ns/1ps
module maxs_host (
  input wire logic i_clk,
  input wire logic i_waitrequest,
  input wire logic [31:0] i_readdata,
  output logic [4:0] o_address,
  output logic o_read,
  output logic o_write,
  output logic [31:0] o_writedata,
  output logic [3:0] o_byteenable
);
  initial begin
    o_address = 5'h00;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = 32'h0000_0000;
    o_byteenable = 4'hF;
  end

  // One access; the request is held until waitrequest is sampled low.
  // Data words go out as plain binary, negatives already in two's complement.
  // Range ratios for vector speed are set by the caller's data, not here.
  task automatic access(input logic wr, input logic [4:0] addr, input logic [31:0] data,
                        output logic [31:0] rdata);
    @(posedge i_clk);
    o_address <= addr;
    o_write <= wr;
    o_read <= !wr;
    o_writedata <= data;
    do @(posedge i_clk); while (i_waitrequest !== 1'b0);
    rdata = i_readdata;
    o_read <= 1'b0;
    o_write <= 1'b0;
  endtask
endmodule

// ===== sim/testbench.sv
/*
  Self-checking testbench for the motion axis mode and status register bank.
  Assumes the host model in maxs_host.sv and the package maxs_pkg.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] addr;
  logic rd, wr, wreq, ext_in = 1'b0, home = 1'b0, iev = 1'b0, pev = 1'b0;
  logic [31:0] wdata, rdata, seed = 32'h06b9_0c93;
  logic [3:0] be, drv = 4'h0;
  logic [23:0] e2 = 24'h00_0000;
  logic [15:0] ef = 16'h0000, gp, extl, exth;
  logic idrv = 1'b0, nxt = 1'b0, irq, step, three;
  logic [2:0] oct = 3'h0;
  logic [1:0] sc = 2'h0, s1, s2, s3, spd;
  int n_mismatch = 0;
  int checks = 0;
  int nstep = 0;

  always #12.5 clk = ~clk;
  always @(posedge clk) if (step === 1'b1) nstep++;

  maxs_host maxs_host_i (.i_clk(clk), .i_waitrequest(wreq), .i_readdata(rdata),
    .o_address(addr), .o_read(rd), .o_write(wr), .o_writedata(wdata), .o_byteenable(be));
  maxs_regs maxs_regs_i (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_AVS_ADDRESS(addr),
    .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be),
    .I_AXIS_DRIVING(drv), .I_AXIS_ERR_TWO(e2), .I_AXIS_ERR_FIN(ef), .I_INTERP_DRIVING(idrv),
    .I_NEXT_NODE_READY(nxt), .I_CIRCLE_OCTANT(oct), .I_PATTERN_STACK_COUNT(sc),
    .I_EXT_STEP_INPUT(ext_in), .I_HOME_DONE(home), .I_INTERP_EVENT(iev),
    .I_PATTERN_EVENT(pev), .O_AVS_WAITREQUEST(wreq), .O_AVS_READDATA(rdata),
    .O_GP_OUT_PINS(gp), .O_MASTER_AXIS_SEL(s1), .O_SECOND_AXIS_SEL(s2),
    .O_THIRD_AXIS_SEL(s3), .O_THREE_AXIS(three), .O_VECTOR_SPEED_MODE(spd),
    .O_INTERP_STEP(step), .O_EXT_MODE_LOW(extl), .O_EXT_MODE_HIGH(exth), .O_IRQ(irq));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic logic [31:0] exp_st();
    logic [3:0] err;
    for (int a = 0; a < 4; a++) err[a] = (|e2[a*6 +: 6]) | (|ef[a*4 +: 4]);
    return {17'h0_0000, sc, oct, nxt, idrv, err, drv};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr32(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] t;
    maxs_host_i.access(1'b1, a, d, t);
  endtask

  task automatic rd32(input logic [4:0] a, output logic [31:0] d);
    maxs_host_i.access(1'b0, a, 32'h0000_0000, d);
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d, g, m;
    int n0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    `CHK({gp, s1, s2, s3, spd, irq}, 25'h000_0000)
    for (int i = 0; i < 8; i++) begin
      g = rnd();
      wr32(maxs_pkg::OFF_GEN_OUT, g);
      cyc(2);
      `CHK(gp, g[15:0])
    end
    wr32(5'h1C, ~g);
    rd32(5'h1C, d);
    `CHK({gp, d}, {g[15:0], 32'h0000_0000})
    rd32(maxs_pkg::OFF_GEN_OUT, d);
    `CHK(d, 32'h0000_0000)
    for (int i = 0; i < 12; i++) begin
      m = rnd();
      if (i < 4) m = {22'h00_0000, i[1:0], 2'h0, i[1:0], i[1:0], i[1:0]};
      wr32(maxs_pkg::OFF_INTERP_MODE, m);
      cyc(2);
      `CHK(s1, m[1:0])
      `CHK(s2, m[3:2])
      `CHK(s3, (m[9:8] == 2'h3) ? m[5:4] : 2'h0)
      `CHK(spd, (m[9:8] == 2'h2) ? 2'h0 : m[9:8])
      `CHK(three, m[9:8] == 2'h3)
    end
    wr32(maxs_pkg::OFF_INTERP_MODE, 32'h0000_033F);
    cyc(2);
    `CHK({s3, three}, 3'h7)
    rst_n = 1'b0;
    cyc(3);
    `CHK({gp, s1, s2, s3, spd, three}, 25'h000_0000)
    @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      g = rnd();
      m = rnd();
      wr32(i ? maxs_pkg::OFF_EXT_LOW : maxs_pkg::OFF_EXT_HIGH, i ? g : m);
      wr32(i ? maxs_pkg::OFF_EXT_HIGH : maxs_pkg::OFF_EXT_LOW, i ? m : g);
      wr32(maxs_pkg::OFF_COMMAND, {24'h00_0000, maxs_pkg::CMD_EXT_MODE});
      rd32(maxs_pkg::OFF_EXT_ACTIVE, d);
      `CHK(d, {m[15:0], g[15:0]})
      wr32(maxs_pkg::OFF_EXT_LOW, ~g);
      cyc(2);
      `CHK({exth, extl}, {m[15:0], g[15:0]})
    end
    for (int en = 0; en < 2; en++) begin
      wr32(maxs_pkg::OFF_INTERP_MODE, en ? 32'h0000_1000 : 32'h0000_0000);
      n0 = nstep;
      wr32(maxs_pkg::OFF_COMMAND, {24'h00_0000, maxs_pkg::CMD_SINGLE_STEP});
      cyc(4);
      `CHK(nstep - n0, en)
      wr32(maxs_pkg::OFF_INTERP_MODE, en ? 32'h0000_0800 : 32'h0000_0000);
      n0 = nstep;
      @(posedge clk);
      ext_in <= 1'b1;
      repeat (4) @(posedge clk);
      ext_in <= 1'b0;
      cyc(2);
      `CHK(nstep - n0, en)
    end
    rd32(maxs_pkg::OFF_MAIN_STATUS, d);
    for (int k = 0; k < 3; k++) begin
      for (int en = 0; en < 2; en++) begin
        m = en ? (32'h0000_4000 << k) : 32'h0000_0000;
        if (k == 2) begin
          wr32(maxs_pkg::OFF_EXT_LOW, en ? 32'h0000_0020 : 32'h0000_0000);
          wr32(maxs_pkg::OFF_COMMAND, {24'h00_0000, maxs_pkg::CMD_EXT_MODE});
        end else wr32(maxs_pkg::OFF_INTERP_MODE, m);
        @(posedge clk);
        {home, pev, iev} <= 3'b001 << k;
        @(posedge clk);
        {home, pev, iev} <= 3'b000;
        cyc(3);
        `CHK(irq, en[0])
        rd32(maxs_pkg::OFF_MAIN_STATUS, d);
        cyc(1);
        `CHK(irq, 1'b0)
      end
    end
    for (int i = 0; i < 10; i++) begin
      g = rnd();
      m = rnd();
      @(posedge clk);
      if (i == 0) {drv, idrv, nxt, oct, sc, e2, ef} <= '1;
      else begin
        {drv, idrv, nxt, oct, sc} <= g[10:0];
        e2 <= (i == 1) ? 24'h00_0000 : g[31:8] & m[23:0];
        ef <= (i == 1) ? 16'h0100 : m[31:16] & g[15:0];
      end
      cyc(1);
      rd32(maxs_pkg::OFF_MAIN_STATUS, d);
      `CHK(d, exp_st())
    end
    close_out();
  end
endmodule

// ===== verilog/maxs_pkg.sv
/*
  Package for the motion axis mode and status register bank.
  Holds register offsets, field positions, reset values and codes.
  Assumes a 32-bit Avalon-MM register port with byte addresses.
*/
package maxs_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_GEN_OUT = 5'h00;
  localparam logic [4:0] OFF_INTERP_MODE = 5'h04;
  localparam logic [4:0] OFF_EXT_LOW = 5'h08;
  localparam logic [4:0] OFF_EXT_HIGH = 5'h0C;
  localparam logic [4:0] OFF_MAIN_STATUS = 5'h10;
  localparam logic [4:0] OFF_COMMAND = 5'h14;
  localparam logic [4:0] OFF_EXT_ACTIVE = 5'h18;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] GEN_OUT_RST = 16'h0000;
  localparam logic [15:0] INTERP_MODE_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Interpolation mode and extension low field positions
  // ----------------------------------------------------------------
  localparam int IM_AX1_LSB = 0;
  localparam int IM_AX2_LSB = 2;
  localparam int IM_AX3_LSB = 4;
  localparam int IM_SPD_LSB = 8;
  localparam int IM_EXT_STEP = 11;
  localparam int IM_CMD_STEP = 12;
  localparam int IM_INTERP_IRQ = 14;
  localparam int IM_PATTERN_IRQ = 15;
  localparam int EXT_HOME_IRQ = 5;

  // ----------------------------------------------------------------
  // Main status field positions
  // ----------------------------------------------------------------
  localparam int MS_DRV_LSB = 0;
  localparam int MS_ERR_LSB = 4;
  localparam int MS_IDRV = 8;
  localparam int MS_NEXT = 9;
  localparam int MS_OCT_LSB = 10;
  localparam int MS_SC_LSB = 13;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MAXS_AXIS_X = 2'h0,
    MAXS_AXIS_Y = 2'h1,
    MAXS_AXIS_Z = 2'h2,
    MAXS_AXIS_U = 2'h3
  } maxs_axis_t;

  typedef enum logic [1:0] {
    MAXS_SPD_OFF = 2'h0,
    MAXS_SPD_TWO = 2'h1,
    MAXS_SPD_BAD = 2'h2,
    MAXS_SPD_THREE = 2'h3
  } maxs_spd_t;

  localparam logic [7:0] CMD_EXT_MODE = 8'h60;
  localparam logic [7:0] CMD_SINGLE_STEP = 8'h3A;

endpackage

// ===== verilog/maxs_regs.sv
/*
  Register bank for axis assignment, interpolation modes, extension modes,
  general outputs and main status of a four-axis motion controller.
  Assumes a host on Avalon-MM and status inputs synchronous to I_CORE_CLK.
*/
`timescale 1ns/1ps
// Overview of operation
// R1 - Each general output bit drives its pin low for 0, high for 1.
// R2 - Reset clears the general output register and drives all pins low.
// R3 - Axis codes are two bits: X 00, Y 01, Z 10, U 11.
// R4 - Mode bits 1:0 master axis, 3:2 second axis, 5:4 third axis.
// R5 - Third axis field is ignored for two-axis interpolation.
// R6 - Bits 9:8 vector speed: 00 off, 01 two, 11 three, 10 illegal.
// R7 - Host sets ranges 1.414 and 1.732 times master in vector speed mode.
// R8 - Bit 11 set: one interpolation step per external step pulse.
// R9 - Bit 12 set: one interpolation step per host step command.
// R10 - Bit 14 enables interrupts during ordinary interpolation.
// R11 - Bit 15 enables interrupts during bit-pattern interpolation.
// R12 - Reset clears the interpolation mode register.
// R13 - Extension command copies both extension registers together, any write order.
// R14 - Extension low bit 5 enables the home search done interrupt.
// R15 - Command data is binary, two's complement, at the designated length.
// R16 - Extension registers have no reset value.
// R17 - Status bits 3:0 show each axis outputting drive pulses.
// R18 - Status bits 7:4 OR of axis error and error-finish bits.
// R19 - Status bit 8 shows interpolation pulses being output.
// R20 - Status bit 9 shows readiness for the next continuous node.
// R21 - Status bits 12:10 show circular octant 0 to 7.
// R22 - Status bits 14:13 show the bit-pattern stack count.
// R23 - Unassigned main status bits read zero.
module maxs_regs #(
  parameter int NUM_AXES = 4
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic [4:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  input wire logic [NUM_AXES-1:0] I_AXIS_DRIVING,
  input wire logic [NUM_AXES*6-1:0] I_AXIS_ERR_TWO,
  input wire logic [NUM_AXES*4-1:0] I_AXIS_ERR_FIN,
  input wire logic I_INTERP_DRIVING,
  input wire logic I_NEXT_NODE_READY,
  input wire logic [2:0] I_CIRCLE_OCTANT,
  input wire logic [1:0] I_PATTERN_STACK_COUNT,
  input wire logic I_EXT_STEP_INPUT,
  input wire logic I_HOME_DONE,
  input wire logic I_INTERP_EVENT,
  input wire logic I_PATTERN_EVENT,
  output logic O_AVS_WAITREQUEST,
  output logic [31:0] O_AVS_READDATA,
  output logic [15:0] O_GP_OUT_PINS,
  output logic [1:0] O_MASTER_AXIS_SEL,
  output logic [1:0] O_SECOND_AXIS_SEL,
  output logic [1:0] O_THIRD_AXIS_SEL,
  output logic O_THREE_AXIS,
  output logic [1:0] O_VECTOR_SPEED_MODE,
  output logic O_INTERP_STEP,
  output logic [15:0] O_EXT_MODE_LOW,
  output logic [15:0] O_EXT_MODE_HIGH,
  output logic O_IRQ
);

  // ----------------------------------------------------------------
  // Bus handshake: one wait cycle, answer on the second edge.
  // ----------------------------------------------------------------
  logic ack_q;
  logic req;
  logic wr_go;
  logic rd_go;
  logic [15:0] wmask;

  assign req = I_AVS_READ | I_AVS_WRITE;
  assign wr_go = I_AVS_WRITE & ack_q;
  assign rd_go = I_AVS_READ & ack_q;
  assign wmask = {{8{I_AVS_BYTEENABLE[1]}}, {8{I_AVS_BYTEENABLE[0]}}};

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_AVS_WAITREQUEST <= 1'b1;
    end else begin
      O_AVS_WAITREQUEST <= ~(req & ~ack_q);
    end
  end

  // ----------------------------------------------------------------
  // Writable registers.
  // ----------------------------------------------------------------
  logic [15:0] gen_out_q;
  logic [15:0] interp_mode_q;
  logic [15:0] ext_low_q;
  logic [15:0] ext_high_q;

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      gen_out_q <= maxs_pkg::GEN_OUT_RST; // [R2]
    end else if (wr_go && I_AVS_ADDRESS == maxs_pkg::OFF_GEN_OUT) begin
      gen_out_q <= (gen_out_q & ~wmask) | (I_AVS_WRITEDATA[15:0] & wmask); // [R15]
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      interp_mode_q <= maxs_pkg::INTERP_MODE_RST; // [R12]
    end else if (wr_go && I_AVS_ADDRESS == maxs_pkg::OFF_INTERP_MODE) begin
      interp_mode_q <= (interp_mode_q & ~wmask) | (I_AVS_WRITEDATA[15:0] & wmask);
    end
  end

  // Staging registers carry no reset; content is undefined until written.
  always_ff @(posedge I_CORE_CLK) begin
    if (wr_go && I_AVS_ADDRESS == maxs_pkg::OFF_EXT_LOW) begin
      ext_low_q <= (ext_low_q & ~wmask) | (I_AVS_WRITEDATA[15:0] & wmask); // [R16]
    end
    if (wr_go && I_AVS_ADDRESS == maxs_pkg::OFF_EXT_HIGH) begin
      ext_high_q <= (ext_high_q & ~wmask) | (I_AVS_WRITEDATA[15:0] & wmask);
    end
  end

  // ----------------------------------------------------------------
  // Command decode.
  // ----------------------------------------------------------------
  logic cmd_wr;
  logic [7:0] cmd_code;

  assign cmd_wr = wr_go && I_AVS_ADDRESS == maxs_pkg::OFF_COMMAND && I_AVS_BYTEENABLE[0];
  assign cmd_code = I_AVS_WRITEDATA[7:0];

  // Both halves move into the active copy in one edge.
  always_ff @(posedge I_CORE_CLK) begin
    if (cmd_wr && cmd_code == maxs_pkg::CMD_EXT_MODE) begin
      O_EXT_MODE_LOW <= ext_low_q; // [R13]
      O_EXT_MODE_HIGH <= ext_high_q; // [R13] [R16]
    end
  end

  // ----------------------------------------------------------------
  // Mode outputs.
  // ----------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_GP_OUT_PINS <= maxs_pkg::GEN_OUT_RST;
    end else begin
      O_GP_OUT_PINS <= gen_out_q; // [R1]
    end
  end

  maxs_pkg::maxs_spd_t spd;
  assign spd = maxs_pkg::maxs_spd_t'(interp_mode_q[maxs_pkg::IM_SPD_LSB +: 2]);

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_MASTER_AXIS_SEL <= maxs_pkg::MAXS_AXIS_X;
      O_SECOND_AXIS_SEL <= maxs_pkg::MAXS_AXIS_X;
      O_THIRD_AXIS_SEL <= maxs_pkg::MAXS_AXIS_X;
      O_THREE_AXIS <= 1'b0;
      O_VECTOR_SPEED_MODE <= maxs_pkg::MAXS_SPD_OFF;
    end else begin
      O_MASTER_AXIS_SEL <= interp_mode_q[maxs_pkg::IM_AX1_LSB +: 2]; // [R3] [R4]
      O_SECOND_AXIS_SEL <= interp_mode_q[maxs_pkg::IM_AX2_LSB +: 2]; // [R4]
      // The third slot only reaches the core when three axes are active.
      O_THIRD_AXIS_SEL <= (spd == maxs_pkg::MAXS_SPD_THREE) ?
                          interp_mode_q[maxs_pkg::IM_AX3_LSB +: 2] :
                          maxs_pkg::MAXS_AXIS_X; // [R5]
      O_THREE_AXIS <= spd == maxs_pkg::MAXS_SPD_THREE;
      // The illegal code is treated as vector speed off.
      unique case (spd)
        maxs_pkg::MAXS_SPD_OFF: O_VECTOR_SPEED_MODE <= maxs_pkg::MAXS_SPD_OFF; // [R6]
        maxs_pkg::MAXS_SPD_TWO: O_VECTOR_SPEED_MODE <= maxs_pkg::MAXS_SPD_TWO; // [R6]
        maxs_pkg::MAXS_SPD_BAD: O_VECTOR_SPEED_MODE <= maxs_pkg::MAXS_SPD_OFF; // [R6]
        maxs_pkg::MAXS_SPD_THREE: O_VECTOR_SPEED_MODE <= maxs_pkg::MAXS_SPD_THREE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Single step: one pulse per external rising edge or host command.
  // ----------------------------------------------------------------
  logic ext_step_q;

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ext_step_q <= 1'b0;
    end else begin
      ext_step_q <= I_EXT_STEP_INPUT;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_INTERP_STEP <= 1'b0;
    end else begin
      O_INTERP_STEP <= (interp_mode_q[maxs_pkg::IM_EXT_STEP] &
                        I_EXT_STEP_INPUT & ~ext_step_q) | // [R8]
                       (interp_mode_q[maxs_pkg::IM_CMD_STEP] & cmd_wr &
                        (cmd_code == maxs_pkg::CMD_SINGLE_STEP)); // [R9]
    end
  end

  // ----------------------------------------------------------------
  // Interrupt line: enabled events held until the status is read.
  // ----------------------------------------------------------------
  logic irq_set;
  logic status_rd;

  assign status_rd = rd_go && I_AVS_ADDRESS == maxs_pkg::OFF_MAIN_STATUS;
  assign irq_set = (interp_mode_q[maxs_pkg::IM_INTERP_IRQ] & I_INTERP_EVENT) | // [R10]
                   (interp_mode_q[maxs_pkg::IM_PATTERN_IRQ] & I_PATTERN_EVENT) | // [R11]
                   (O_EXT_MODE_LOW[maxs_pkg::EXT_HOME_IRQ] & I_HOME_DONE); // [R14]

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_IRQ <= 1'b0;
    end else if (irq_set) begin
      O_IRQ <= 1'b1;
    end else if (status_rd) begin
      O_IRQ <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Main status assembly.
  // ----------------------------------------------------------------
  logic [15:0] status;
  logic [NUM_AXES-1:0] axis_err;

  for (genvar a = 0; a < NUM_AXES; a++) begin : g_err
    assign axis_err[a] = |I_AXIS_ERR_TWO[a*6 +: 6] | |I_AXIS_ERR_FIN[a*4 +: 4]; // [R18]
  end

  always_comb begin
    status = 16'h0000; // [R23]
    status[maxs_pkg::MS_DRV_LSB +: 4] = I_AXIS_DRIVING[3:0]; // [R17]
    status[maxs_pkg::MS_ERR_LSB +: 4] = axis_err[3:0]; // [R18]
    status[maxs_pkg::MS_IDRV] = I_INTERP_DRIVING; // [R19]
    status[maxs_pkg::MS_NEXT] = I_NEXT_NODE_READY; // [R20]
    status[maxs_pkg::MS_OCT_LSB +: 3] = I_CIRCLE_OCTANT; // [R21]
    status[maxs_pkg::MS_SC_LSB +: 2] = I_PATTERN_STACK_COUNT; // [R22]
  end

  // Write-only registers read zero; the active extension copy is readable.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_AVS_READDATA <= 32'h0000_0000;
    end else if (req && !ack_q) begin
      if (I_AVS_ADDRESS == maxs_pkg::OFF_MAIN_STATUS) begin
        O_AVS_READDATA <= {16'h0000, status};
      end else if (I_AVS_ADDRESS == maxs_pkg::OFF_EXT_ACTIVE) begin
        O_AVS_READDATA <= {O_EXT_MODE_HIGH, O_EXT_MODE_LOW};
      end else begin
        O_AVS_READDATA <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  a_gpout_follows: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R1]
    O_GP_OUT_PINS == $past(gen_out_q))
    else $error("gp out mismatch");

  a_gen_write: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R1] [R15]
    wr_go && I_AVS_ADDRESS == maxs_pkg::OFF_GEN_OUT && I_AVS_BYTEENABLE[1:0] == 2'h3 |=>
    gen_out_q == $past(I_AVS_WRITEDATA[15:0])) else $error("gp write lost");

  a_gpout_reset: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R2]
    !$past(I_RST_N) |-> O_GP_OUT_PINS == 16'h0000)
    else $error("gp out not cleared");

  a_mode_reset: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R12]
    !$past(I_RST_N) |-> interp_mode_q == 16'h0000)
    else $error("mode not cleared");

  a_status_high: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R23]
    rd_go && I_AVS_ADDRESS == maxs_pkg::OFF_MAIN_STATUS |-> O_AVS_READDATA[31:15] == 17'h0_0000)
    else $error("status spare bits set");

  a_status_drv: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R17]
    rd_go && I_AVS_ADDRESS == maxs_pkg::OFF_MAIN_STATUS |->
    O_AVS_READDATA[3:0] == $past(I_AXIS_DRIVING[3:0])) else $error("drv bits");

  a_status_err: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R18]
    rd_go && I_AVS_ADDRESS == maxs_pkg::OFF_MAIN_STATUS |->
    O_AVS_READDATA[7:4] == $past(axis_err[3:0])) else $error("err bits");

  a_status_idrv: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R19]
    rd_go && I_AVS_ADDRESS == maxs_pkg::OFF_MAIN_STATUS |->
    O_AVS_READDATA[8] == $past(I_INTERP_DRIVING)) else $error("interp drive bit");

  a_status_next: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R20]
    rd_go && I_AVS_ADDRESS == maxs_pkg::OFF_MAIN_STATUS |->
    O_AVS_READDATA[9] == $past(I_NEXT_NODE_READY)) else $error("next node bit");

  a_status_oct: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R21]
    rd_go && I_AVS_ADDRESS == maxs_pkg::OFF_MAIN_STATUS |->
    O_AVS_READDATA[12:10] == $past(I_CIRCLE_OCTANT)) else $error("octant bits");

  a_status_count: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R22]
    rd_go && I_AVS_ADDRESS == maxs_pkg::OFF_MAIN_STATUS |->
    O_AVS_READDATA[14:13] == $past(I_PATTERN_STACK_COUNT)) else $error("stack count bits");

  a_master_sel: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R3] [R4]
    O_MASTER_AXIS_SEL == $past(interp_mode_q[maxs_pkg::IM_AX1_LSB +: 2]))
    else $error("master axis select");

  a_second_sel: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R4]
    O_SECOND_AXIS_SEL == $past(interp_mode_q[maxs_pkg::IM_AX2_LSB +: 2]))
    else $error("second axis select");

  a_third_sel: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R5]
    spd == maxs_pkg::MAXS_SPD_THREE |=> O_THIRD_AXIS_SEL == $past(interp_mode_q[5:4]))
    else $error("third axis select");

  a_third_ignored: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R5]
    spd != maxs_pkg::MAXS_SPD_THREE |=> O_THIRD_AXIS_SEL == maxs_pkg::MAXS_AXIS_X)
    else $error("third axis used");

  a_spd_illegal: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R6]
    spd == maxs_pkg::MAXS_SPD_BAD |=> O_VECTOR_SPEED_MODE == maxs_pkg::MAXS_SPD_OFF)
    else $error("illegal speed code passed");

  a_spd_pass: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R6]
    spd != maxs_pkg::MAXS_SPD_BAD |=> O_VECTOR_SPEED_MODE == $past(spd))
    else $error("speed mode lost");

  a_three_flag: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R6]
    O_THREE_AXIS == ($past(interp_mode_q[maxs_pkg::IM_SPD_LSB +: 2]) == 2'h3))
    else $error("three axis flag");

  a_ext_step: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R8]
    interp_mode_q[maxs_pkg::IM_EXT_STEP] && $rose(I_EXT_STEP_INPUT) |=> O_INTERP_STEP)
    else $error("external step lost");

  a_ext_level: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R8]
    $past(I_RST_N) && !interp_mode_q[maxs_pkg::IM_CMD_STEP] && $stable(I_EXT_STEP_INPUT)
    |=> !O_INTERP_STEP) else $error("step without edge");

  a_cmd_step: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R9]
    interp_mode_q[maxs_pkg::IM_CMD_STEP] && cmd_wr && cmd_code == maxs_pkg::CMD_SINGLE_STEP
    |=> O_INTERP_STEP) else $error("command step lost");

  a_no_step: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R9]
    !interp_mode_q[maxs_pkg::IM_EXT_STEP] && !interp_mode_q[maxs_pkg::IM_CMD_STEP]
    |=> !O_INTERP_STEP) else $error("step while disabled");

  a_ext_copy: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R13]
    cmd_wr && cmd_code == maxs_pkg::CMD_EXT_MODE |=>
    O_EXT_MODE_LOW == $past(ext_low_q) && O_EXT_MODE_HIGH == $past(ext_high_q))
    else $error("extension copy");

  a_irq_home: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R14]
    O_EXT_MODE_LOW[maxs_pkg::EXT_HOME_IRQ] && I_HOME_DONE |=> O_IRQ)
    else $error("home irq missing");

  a_irq_interp: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R10]
    interp_mode_q[maxs_pkg::IM_INTERP_IRQ] && I_INTERP_EVENT |=> O_IRQ)
    else $error("interp irq missing");

  a_irq_pattern: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R11]
    interp_mode_q[maxs_pkg::IM_PATTERN_IRQ] && I_PATTERN_EVENT |=> O_IRQ)
    else $error("pattern irq missing");

  a_irq_quiet: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // [R10] [R11]
    !O_IRQ && !irq_set |=> !O_IRQ)
    else $error("irq without event");

  a_irq_clear: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    status_rd && !irq_set |=> !O_IRQ)
    else $error("irq not cleared");

  a_bus_answer: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    req && O_AVS_WAITREQUEST && !ack_q |=> !O_AVS_WAITREQUEST)
    else $error("bus answer late");

  a_bus_single: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    !O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
    else $error("answer held too long");

endmodule
